// ==== rtl/wgl_axil_slave.sv ====
/*
  AXI4-Lite slave front end: one write and one read in flight, 8-bit registers
  in the low byte lane. Assumes the register core decodes combinationally.
*/
`timescale 1ns/1ps
`default_nettype none

module wgl_axil_slave (
  input  wire logic        clk,
  input  wire logic        rst_b,
  wgl_reg_if.bus           rif,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  wgl_pkg::wgl_axil_s s;
  wgl_pkg::wgl_axil_s next_s;
  logic               do_wr;
  logic               do_rd;

  always_comb begin
    next_s = s;
    do_wr = s.aw_full && s.w_full && !s.bvalid;
    do_rd = arvalid && s.arready;
    rif.wr_en = do_wr && s.w_lane;
    rif.wr_idx = s.aw_idx;
    rif.wr_data = s.w_data;
    rif.rd_idx = araddr[7:2];
    if (awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_full = 1'b1;
      next_s.aw_idx = awaddr[7:2];
    end
    if (wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.w_full = 1'b1;
      next_s.w_data = wdata[7:0];
      // upper lanes carry no register bits
      next_s.w_lane = wstrb[0];
    end
    if (do_wr) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = rif.wr_hit ? wgl_pkg::RESP_OKAY : wgl_pkg::RESP_SLVERR;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    if (do_rd) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = {24'h00_0000, rif.rd_data};
      next_s.rresp = rif.rd_hit ? wgl_pkg::RESP_OKAY : wgl_pkg::RESP_SLVERR;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;

endmodule // wgl_axil_slave

`default_nettype wire

// ==== rtl/wgl_pkg.sv ====
/*
  Shared constants and types of the white-level gain loop register bank.
  Assumes a single clock domain; register byte address is four times the index.
*/
`default_nettype none

package wgl_pkg;

  // register indices; byte address = index * 4
  localparam logic [5:0] IDX_CONFIG      = 6'h28;
  localparam logic [5:0] IDX_START_HIGH  = 6'h2A;
  localparam logic [5:0] IDX_START_LOW   = 6'h2B;
  localparam logic [5:0] IDX_LEN_HIGH    = 6'h2C;
  localparam logic [5:0] IDX_LEN_LOW     = 6'h2D;
  localparam logic [5:0] IDX_LINE_COUNT  = 6'h2E;
  localparam logic [5:0] IDX_TGT_HIGH    = 6'h2F;
  localparam logic [5:0] IDX_TGT_LOW     = 6'h30;
  localparam logic [5:0] IDX_TOLERANCE   = 6'h31;
  localparam logic [5:0] IDX_BLK_INT     = 6'h32;
  localparam logic [5:0] IDX_STATUS      = 6'h33;
  localparam logic [5:0] IDX_RSV_A       = 6'h34;
  localparam logic [5:0] IDX_RSV_B       = 6'h35;

  // reset values
  localparam logic [7:0] RST_START_HIGH  = 8'h00;
  localparam logic [7:0] RST_START_LOW   = 8'h00;
  localparam logic [7:0] RST_LEN_HIGH    = 8'h00;
  localparam logic [7:0] RST_LEN_LOW     = 8'h00;
  localparam logic [7:0] RST_LINE_COUNT  = 8'h10;
  localparam logic [7:0] RST_TGT_HIGH    = 8'hE0;
  localparam logic [7:0] RST_TGT_LOW     = 8'h00;
  localparam logic [7:0] RST_TOLERANCE   = 8'h28;
  localparam logic [7:0] RST_BLK_INT     = 8'h00;
  localparam logic [7:0] RST_RSV_A       = 8'h32;
  localparam logic [7:0] RST_RSV_B       = 8'h54;

  // field positions
  localparam int CFG_RUN_BIT      = 0;
  localparam int CFG_PIN_DIS_BIT  = 4;
  localparam int CFG_TRIG_SEL_BIT = 5;
  localparam int TGT_LOW_BIT      = 7;

  localparam logic [9:0] TARGET_BASE   = 10'h200;
  localparam logic [2:0] BLK_INT_MAX   = 3'h5;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    WGL_IDLE,
    WGL_SKIP,
    WGL_WINDOW
  } wgl_phase_e;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic        w_full;
    logic [5:0]  aw_idx;
    logic [7:0]  w_data;
    logic        w_lane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wgl_axil_s;

  typedef struct packed {
    logic            cfg_run;
    logic            cfg_pin_dis;
    logic            cfg_trig_sel;
    logic [15:0]     start;
    logic [15:0]     len;
    logic [7:0]      line_count;
    logic [7:0]      tgt_high;
    logic            tgt_low_bit;
    logic [5:0]      tol;
    logic [2:0]      blk_int;
    logic [5:0]      status;
    logic            trig_prev;
    logic            pin_prev;
    wgl_phase_e      phase;
    logic [15:0]     act_start;
    logic [15:0]     act_len;
    logic [15:0]     pix_cnt;
    logic [7:0]      lines_done;
    logic            line_end;
    logic [5:0][9:0] peak;
    logic            cal_active;
    logic            window_open;
    logic [9:0]      target;
    logic [3:0]      blk_shift;
  } wgl_core_s;

endpackage

`default_nettype wire

// ==== rtl/wgl_reg_if.sv ====
/*
  Internal register access carrier between the bus slave and the register core.
  Assumes the core answers hit and read data combinationally from the index.
*/
`timescale 1ns/1ps
`default_nettype none

interface wgl_reg_if;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_hit;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic       rd_hit;

  modport bus  (output wr_en, output wr_idx, output wr_data, output rd_idx,
                input wr_hit, input rd_data, input rd_hit);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx,
                output wr_hit, output rd_data, output rd_hit);
endinterface

`default_nettype wire

// ==== rtl/wgl_top.sv ====
/*
  White-level gain loop configuration and status bank with line sequencer.
  Assumes strobes, run pin and pixel stream are synchronous to clk (pixel clock).
*/
// Summary of operation
// [R1] the peak window spans a 16-bit pixel length from the start pixel, 0 to 65535
// [R2] the loop runs for an 8-bit number of lines, reset value 0x10
// [R3] while the run pin is high the loop keeps running whatever the line count
// [R4] the target is 512 plus target_high bits and bit 7 of target_low, default 960
// [R5] a 6-bit tolerance in bits 5:0 sets the allowed error, bits 7:6 reserved
// [R6] while active a 3-bit code selects black-loop division by 2 up to 64
// [R7] a read-only status holds one convergence error bit per channel, bits 7:6 zero
// [R8] the host keeps the two registers after status at 0x32 and 0x54
// [R9] the window start counts 16-bit pixels after the selected trigger rising edge
// [R10] writing one to the run bit enables the loop; it reads 0 ready, 1 enabled
// [R11] trigger select 0 uses the line clamp strobe, 1 the black clamp strobe
// [R12] a channel error bit sets when the run ends off target, clears at run start
// [R13] window high bytes are bits 15:8 and values take effect at the next trigger
`timescale 1ns/1ps
`default_nettype none

module wgl_top #(
  parameter int CHANNELS = 6,
  parameter int PIX_W    = 10
) (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [7:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           line_clamp_strobe,
  input  wire logic                           black_clamp_strobe,
  input  wire logic                           gain_cal_run,
  input  wire logic                           pixel_valid,
  input  wire logic [CHANNELS-1:0][PIX_W-1:0] pixel_data,
  output logic                                cal_active,
  output logic                                peak_window_open,
  output logic [9:0]                          gain_target_value,
  output logic [3:0]                          black_int_shift
);

  wgl_reg_if rif ();

  wgl_axil_slave u_slave (
    .clk     (clk),
    .rst_b   (rst_b),
    .rif     (rif.bus),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready)
  );

  wgl_pkg::wgl_core_s s;
  wgl_pkg::wgl_core_s next_s;

  logic [5:0][9:0] pk_max;
  logic [5:0]      off_target;

  // per-channel running maximum and tolerance check
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++) begin : g_chan
      logic [9:0] px;
      logic [9:0] diff;
      assign px = (ch < CHANNELS) ? 10'(pixel_data[ch]) : 10'h000;
      assign pk_max[ch] = (px > s.peak[ch]) ? px : s.peak[ch];
      assign diff = (s.peak[ch] > s.target) ? 10'(s.peak[ch] - s.target)
                                            : 10'(s.target - s.peak[ch]);
      assign off_target[ch] = diff > {4'h0, s.tol}; // [R12]
    end
  endgenerate

  logic trig;
  logic trig_rise;
  logic pin_hold;
  logic pin_rise;
  logic run_start;
  logic sw_abort;
  logic finish;
  logic line_done;
  logic sample;

  always_comb begin
    next_s = s;
    trig = s.cfg_trig_sel ? black_clamp_strobe : line_clamp_strobe; // [R11]
    trig_rise = trig && !s.trig_prev; // [R9]
    pin_hold = gain_cal_run && !s.cfg_pin_dis;
    pin_rise = pin_hold && !s.pin_prev;
    run_start = 1'b0;
    sw_abort = 1'b0;
    line_done = 1'b0;
    sample = 1'b0;
    next_s.trig_prev = trig;
    next_s.pin_prev = gain_cal_run;
    next_s.line_end = 1'b0;

    // register writes
    rif.wr_hit = 1'b1;
    case (rif.wr_idx)
      wgl_pkg::IDX_CONFIG, wgl_pkg::IDX_START_HIGH, wgl_pkg::IDX_START_LOW,
      wgl_pkg::IDX_LEN_HIGH, wgl_pkg::IDX_LEN_LOW, wgl_pkg::IDX_LINE_COUNT,
      wgl_pkg::IDX_TGT_HIGH, wgl_pkg::IDX_TGT_LOW, wgl_pkg::IDX_TOLERANCE,
      wgl_pkg::IDX_BLK_INT, wgl_pkg::IDX_STATUS, wgl_pkg::IDX_RSV_A,
      wgl_pkg::IDX_RSV_B: rif.wr_hit = 1'b1;
      default: rif.wr_hit = 1'b0;
    endcase
    if (rif.wr_en) begin
      case (rif.wr_idx)
        wgl_pkg::IDX_CONFIG: begin
          next_s.cfg_trig_sel = rif.wr_data[wgl_pkg::CFG_TRIG_SEL_BIT]; // [R11]
          next_s.cfg_pin_dis = rif.wr_data[wgl_pkg::CFG_PIN_DIS_BIT];
          next_s.cfg_run = rif.wr_data[wgl_pkg::CFG_RUN_BIT]; // [R10]
          run_start = rif.wr_data[wgl_pkg::CFG_RUN_BIT] && !s.cfg_run;
          sw_abort = !rif.wr_data[wgl_pkg::CFG_RUN_BIT] && s.cfg_run && !pin_hold;
        end
        wgl_pkg::IDX_START_HIGH: next_s.start[15:8] = rif.wr_data; // [R13]
        wgl_pkg::IDX_START_LOW:  next_s.start[7:0] = rif.wr_data;
        wgl_pkg::IDX_LEN_HIGH:   next_s.len[15:8] = rif.wr_data; // [R1]
        wgl_pkg::IDX_LEN_LOW:    next_s.len[7:0] = rif.wr_data;
        wgl_pkg::IDX_LINE_COUNT: next_s.line_count = rif.wr_data; // [R2]
        wgl_pkg::IDX_TGT_HIGH:   next_s.tgt_high = rif.wr_data; // [R4]
        wgl_pkg::IDX_TGT_LOW:    next_s.tgt_low_bit = rif.wr_data[wgl_pkg::TGT_LOW_BIT];
        wgl_pkg::IDX_TOLERANCE:  next_s.tol = rif.wr_data[5:0]; // [R5]
        wgl_pkg::IDX_BLK_INT:    next_s.blk_int = rif.wr_data[2:0]; // [R6]
        // status is read only; reserved pair holds its defaults
        default: ;
      endcase
    end
    run_start = (run_start || pin_rise) && !s.cal_active;

    // line sequencer
    if (s.cal_active && trig_rise) begin
      next_s.act_start = s.start; // [R13]
      next_s.act_len = s.len;
      next_s.pix_cnt = 16'h0000;
      next_s.peak = '0;
      next_s.phase = wgl_pkg::WGL_SKIP;
    end else if (s.cal_active && pixel_valid) begin
      case (s.phase)
        wgl_pkg::WGL_SKIP: begin
          if (s.pix_cnt == s.act_start) begin // [R9]
            if (s.act_len == 16'h0000) begin
              line_done = 1'b1;
            end else begin
              sample = 1'b1;
              next_s.pix_cnt = 16'h0001;
              next_s.phase = wgl_pkg::WGL_WINDOW;
              line_done = (s.act_len == 16'h0001);
            end
          end else begin
            next_s.pix_cnt = 16'(s.pix_cnt + 16'h0001);
          end
        end
        wgl_pkg::WGL_WINDOW: begin
          sample = 1'b1;
          next_s.pix_cnt = 16'(s.pix_cnt + 16'h0001);
          line_done = (16'(s.pix_cnt + 16'h0001) == s.act_len); // [R1]
        end
        wgl_pkg::WGL_IDLE: ;
        default: next_s.phase = wgl_pkg::WGL_IDLE;
      endcase
    end
    if (sample) begin
      next_s.peak = pk_max;
    end
    if (line_done) begin
      next_s.phase = wgl_pkg::WGL_IDLE;
      next_s.line_end = 1'b1;
      if (s.lines_done != 8'hFF) begin
        next_s.lines_done = 8'(s.lines_done + 8'h01);
      end
    end

    // run end: after a line or a run-bit clear, never while the pin holds the loop on
    finish = s.cal_active && s.line_end && !pin_hold
             && (s.lines_done >= s.line_count); // [R2] [R3]
    if (finish) begin
      next_s.cfg_run = 1'b0; // [R10]
      next_s.status = off_target; // [R12]
    end
    if (run_start) begin
      next_s.status = 6'h00; // [R12]
      next_s.lines_done = 8'h00;
      next_s.phase = wgl_pkg::WGL_IDLE;
    end
    next_s.cal_active = (s.cal_active || run_start) && !finish && !sw_abort;
    if (!next_s.cal_active) begin
      next_s.phase = wgl_pkg::WGL_IDLE;
    end

    next_s.target = wgl_pkg::TARGET_BASE + {1'b0, next_s.tgt_high, next_s.tgt_low_bit}; // [R4]
    next_s.blk_shift = (next_s.cal_active && next_s.blk_int <= wgl_pkg::BLK_INT_MAX)
                       ? 4'({1'b0, next_s.blk_int} + 4'h1) : 4'h0; // [R6]
    next_s.window_open = (next_s.phase == wgl_pkg::WGL_WINDOW);

    // register reads
    rif.rd_hit = 1'b1;
    case (rif.rd_idx)
      wgl_pkg::IDX_CONFIG: rif.rd_data = {2'b00, s.cfg_trig_sel, s.cfg_pin_dis,
                                          3'b000, s.cfg_run}; // [R10]
      wgl_pkg::IDX_START_HIGH: rif.rd_data = s.start[15:8];
      wgl_pkg::IDX_START_LOW:  rif.rd_data = s.start[7:0];
      wgl_pkg::IDX_LEN_HIGH:   rif.rd_data = s.len[15:8];
      wgl_pkg::IDX_LEN_LOW:    rif.rd_data = s.len[7:0];
      wgl_pkg::IDX_LINE_COUNT: rif.rd_data = s.line_count;
      wgl_pkg::IDX_TGT_HIGH:   rif.rd_data = s.tgt_high;
      wgl_pkg::IDX_TGT_LOW:    rif.rd_data = {s.tgt_low_bit, 7'h00};
      wgl_pkg::IDX_TOLERANCE:  rif.rd_data = {2'b00, s.tol}; // [R5]
      wgl_pkg::IDX_BLK_INT:    rif.rd_data = {5'h00, s.blk_int};
      wgl_pkg::IDX_STATUS:     rif.rd_data = {2'b00, s.status}; // [R7]
      wgl_pkg::IDX_RSV_A:      rif.rd_data = wgl_pkg::RST_RSV_A; // [R8]
      wgl_pkg::IDX_RSV_B:      rif.rd_data = wgl_pkg::RST_RSV_B;
      default: begin
        rif.rd_data = 8'h00;
        rif.rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{start:       {wgl_pkg::RST_START_HIGH, wgl_pkg::RST_START_LOW},
             len:         {wgl_pkg::RST_LEN_HIGH, wgl_pkg::RST_LEN_LOW},
             line_count:  wgl_pkg::RST_LINE_COUNT,
             tgt_high:    wgl_pkg::RST_TGT_HIGH,
             tgt_low_bit: wgl_pkg::RST_TGT_LOW[wgl_pkg::TGT_LOW_BIT],
             tol:         wgl_pkg::RST_TOLERANCE[5:0],
             blk_int:     wgl_pkg::RST_BLK_INT[2:0],
             phase:       wgl_pkg::WGL_IDLE,
             target:      wgl_pkg::TARGET_BASE
                          + {1'b0, wgl_pkg::RST_TGT_HIGH,
                             wgl_pkg::RST_TGT_LOW[wgl_pkg::TGT_LOW_BIT]},
             default:     '0};
    end else begin
      s <= next_s;
    end
  end

  assign cal_active        = s.cal_active;
  assign peak_window_open  = s.window_open;
  assign gain_target_value = s.target;
  assign black_int_shift   = s.blk_shift;

endmodule // wgl_top

`default_nettype wire

// ==== testbench/test_white_level_gain_loop_config.sv ====
/*
  Self-checking bench for the gain loop bank: register access and run control.
  Assumes the host model drives the line side; checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none

module test_white_level_gain_loop_config;
  logic            clk, rst_b, gain_cal_run;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready;
  logic [1:0]      bresp, rresp;
  logic            lclamp, bclamp, pvalid, active, win_open;
  logic [5:0][9:0] pdata;
  logic [9:0]      target;
  logic [3:0]      shift;
  int              errors, cmp_count;
  // per channel 960, 1000, 1001, 919, 920, 0 against target 960, tolerance 40
  logic [5:0][9:0] lvl = {10'h000, 10'h398, 10'h397, 10'h3E9, 10'h3E8, 10'h3C0};

  wgl_top u_wgl_top (
    .clk, .rst_b, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_clamp_strobe(lclamp), .black_clamp_strobe(bclamp), .gain_cal_run,
    .pixel_valid(pvalid), .pixel_data(pdata), .cal_active(active),
    .peak_window_open(win_open), .gain_target_value(target), .black_int_shift(shift)
  );
  wgl_host_model u_wgl_host_model (
    .clk, .line_clamp_strobe(lclamp), .black_clamp_strobe(bclamp),
    .pixel_valid(pvalid), .pixel_data(pdata)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] ersp);
    logic aw;
    logic w;
    logic [1:0] r;
    aw = 1'b1;
    w = 1'b1;
    r = 2'h3;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    chk("bresp", ersp, r);
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] ersp);
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'hFFFF_FFFF;
    r = 2'h3;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    chk("rdata", {24'h00_0000, exp}, d);
    chk("rresp", ersp, r);
    @(posedge clk);
  endtask

  task automatic t_reset_vals();
    logic [7:0] rv [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
                            8'hE0, 8'h00, 8'h28, 8'h00, 8'h00, 8'h32, 8'h54};
    for (int i = 0; i < 14; i++)
      rd_chk(6'h28 + 6'(i), rv[i], (i == 1) ? 2'h2 : 2'h0);
    chk("target", 32'h0000_03C0, target);
  endtask

  task automatic t_access();
    wr(6'h33, 8'hFF, 2'h0);
    rd_chk(6'h33, 8'h00, 2'h0);
    wr(6'h29, 8'h5A, 2'h2);
    wr(6'h2C, 8'hAB, 2'h0);
    rd_chk(6'h2C, 8'hAB, 2'h0);
    wr(6'h2D, 8'hCD, 2'h0);
    rd_chk(6'h2D, 8'hCD, 2'h0);
    wr(6'h2E, 8'hFF, 2'h0);
    rd_chk(6'h2E, 8'hFF, 2'h0);
    wr(6'h31, 8'hD5, 2'h0);
    rd_chk(6'h31, 8'h15, 2'h0);
  endtask

  task automatic t_target();
    wr(6'h2F, 8'h12, 2'h0);
    wr(6'h30, 8'h80, 2'h0);
    chk("target", 32'h0000_0225, target);
    wr(6'h30, 8'h7F, 2'h0);
    chk("target", 32'h0000_0224, target);
    wr(6'h2F, 8'hE0, 2'h0);
    wr(6'h30, 8'h00, 2'h0);
    chk("target", 32'h0000_03C0, target);
  endtask

  task automatic t_blk_codes();
    for (int c = 0; c < 8; c++) begin
      wr(6'h32, 8'(c), 2'h0);
      wr(6'h28, 8'h01, 2'h0);
      repeat (2) @(posedge clk);
      chk("active", 32'h0000_0001, active);
      chk("shift", (c < 6) ? 32'(c + 1) : 32'h0000_0000, shift);
      rd_chk(6'h28, 8'h01, 2'h0);
      wr(6'h28, 8'h00, 2'h0);
      repeat (2) @(posedge clk);
      chk("shift", 32'h0000_0000, shift);
    end
  endtask

  task automatic t_lines();
    wr(6'h2A, 8'h00, 2'h0);
    wr(6'h2B, 8'h03, 2'h0);
    wr(6'h2C, 8'h00, 2'h0);
    wr(6'h2D, 8'h04, 2'h0);
    wr(6'h2E, 8'h02, 2'h0);
    wr(6'h31, 8'h28, 2'h0);
    wr(6'h28, 8'h01, 2'h0);
    fork
      u_wgl_host_model.send_line(1'b0, lvl, 3, 4);
      #65 chk("win", 32'h1, win_open);
    join
    chk("active", 32'h0000_0001, active);
    u_wgl_host_model.send_line(1'b0, lvl, 3, 4);
    chk("active", 32'h0000_0000, active);
    rd_chk(6'h28, 8'h00, 2'h0);
    rd_chk(6'h33, 8'h2C, 2'h0);
    wr(6'h28, 8'h01, 2'h0);
    rd_chk(6'h33, 8'h00, 2'h0);
    wr(6'h28, 8'h00, 2'h0);
  endtask

  task automatic t_trig_sel();
    wr(6'h2E, 8'h00, 2'h0);
    wr(6'h28, 8'h21, 2'h0);
    u_wgl_host_model.send_line(1'b0, lvl, 3, 4);
    chk("active", 32'h0000_0001, active);
    u_wgl_host_model.send_line(1'b1, lvl, 3, 4);
    chk("active", 32'h0000_0000, active);
    wr(6'h28, 8'h00, 2'h0);
  endtask

  task automatic t_pin();
    gain_cal_run <= 1'b1;
    repeat (3) @(posedge clk);
    chk("active", 32'h0000_0001, active);
    u_wgl_host_model.send_line(1'b0, lvl, 3, 4);
    u_wgl_host_model.send_line(1'b0, lvl, 3, 4);
    chk("active", 32'h0000_0001, active);
    gain_cal_run <= 1'b0;
    u_wgl_host_model.send_line(1'b0, lvl, 3, 4);
    chk("active", 32'h0000_0000, active);
  endtask

  initial begin
    #400_000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    gain_cal_run = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_access();
    t_target();
    t_blk_codes();
    t_lines();
    t_trig_sel();
    t_pin();
    give_verdict();
  end
endmodule // test_white_level_gain_loop_config

`default_nettype wire

// ==== testbench/wgl_host_model.sv ====
/*
  Line side of the host: trigger strobes and a short pixel stream per line.
  Assumes the bench calls send_line right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module wgl_host_model (
  input  wire logic       clk,
  output logic            line_clamp_strobe,
  output logic            black_clamp_strobe,
  output logic            pixel_valid,
  output logic [5:0][9:0] pixel_data
);
  initial begin
    line_clamp_strobe = 1'b0;
    black_clamp_strobe = 1'b0;
    pixel_valid = 1'b0;
    pixel_data = '0;
  end

  // ten pixels a line; full scale outside the window
  task automatic send_line(input logic use_blk, input logic [5:0][9:0] lvl,
                           input int start, input int len);
    @(posedge clk);
    if (use_blk)
      black_clamp_strobe <= 1'b1;
    else
      line_clamp_strobe <= 1'b1;
    @(posedge clk);
    line_clamp_strobe <= 1'b0;
    black_clamp_strobe <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      pixel_valid <= 1'b1;
      pixel_data <= (k >= start && k < start + len) ? lvl : {6{10'h3FF}};
      @(posedge clk);
    end
    pixel_valid <= 1'b0;
    // idle data toggles: no stale pixel
    pixel_data <= ~pixel_data;
    repeat (4) @(posedge clk);
  endtask
endmodule // wgl_host_model

`default_nettype wire

// ==== testbench/wgl_top_checker.sv ====
/*
  Concurrent checks on the ports of the gain loop bank top.
  Assumes one clock domain; attached by the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none

module wgl_top_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        gain_cal_run,
  input wire logic        cal_active,
  input wire logic        peak_window_open,
  input wire logic [9:0]  gain_target_value,
  input wire logic [3:0]  black_int_shift
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_tgt_base; gain_target_value[9] == 1'b1; endproperty
  a_tgt_base: assert property (p_tgt_base) else $error("target below base");
  property p_shift_idle; !cal_active |-> black_int_shift == 4'h0; endproperty
  a_shift_idle: assert property (p_shift_idle) else $error("shift while idle");
  property p_shift_max; cal_active |-> black_int_shift <= 4'h6; endproperty
  a_shift_max: assert property (p_shift_max) else $error("shift above 64");
  property p_win_act; peak_window_open |-> cal_active; endproperty
  a_win_act: assert property (p_win_act) else $error("window while idle");
  property p_pin_start; $rose(gain_cal_run) |-> ##[1:3] cal_active; endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin did not start run");
  property p_pin_hold; gain_cal_run && cal_active |=> cal_active; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("run ended with pin high");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no write response");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule // wgl_top_checker

bind wgl_top wgl_top_checker u_wgl_top_checker (
  .clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .gain_cal_run, .cal_active, .peak_window_open, .gain_target_value,
  .black_int_shift
);

`default_nettype wire
